// [src/temp_conv_map.svh]
// register offsets, field positions, reset values and timing figures
`ifndef TEMP_CONV_MAP_SVH
`define TEMP_CONV_MAP_SVH
`define PTR_TEMP 3'h0
`define PTR_CFG 3'h1
`define PTR_HYST 3'h2
`define PTR_OTL 3'h3
`define PTR_ADC 3'h4
`define PTR_CFG2 3'h5
`define CFG_CHAN_HI 7
`define CFG_CHAN_LO 5
`define CFG_FQ_HI 4
`define CFG_FQ_LO 3
`define CFG_POL 2
`define CFG_MODE 1
`define CFG_SHDN 0
`define CFG2_PIN 1
`define CFG2_TEST 0
`define CFG_RST 8'h00
`define CFG2_RST 2'h0
`define LIMIT_RST 9'h000
`define CHAN_TEMP 3'h0
`define CLK_MHZ 100
`define T_HOLD_DLY_US 3
`define T_PWRUP_US 4
`define T_CONV_AIN_US 15
`define T_CONV_TEMP_US 30
`define T_PERIOD_US 355
`define CYC(us) ((us) * `CLK_MHZ)
`endif

// [src/temp_conv_pkg.sv]
// types shared by the conversion and register core
package temp_conv_pkg;
    typedef enum logic [1:0] {C_TRACK, C_ARM, C_DELAY, C_CONVERT} conv_state_t;
    typedef enum logic [2:0] {
        B_IDLE, B_ADDR, B_ACKA, B_WR, B_ACKW, B_RD, B_ACKR
    } bus_state_t;
    typedef struct packed {
        logic [2:0] channel;
        logic powered;
        logic hold;
        logic ref_amp_en;
    } afe_ctrl_t;
    typedef struct packed {
        logic polarity;
        logic int_mode;
        logic [2:0] fault_needed;
        logic [8:0] hysteresis_limit;
        logic [8:0] over_temp_limit;
    } ot_cfg_t;
    typedef struct packed {
        conv_state_t cs;
        bus_state_t bs;
        logic [2:0] conv_chan;
        logic scl_p;
        logic sda_p;
        logic cs_p;
        logic [3:0] bitcnt;
        logic [7:0] sh;
        logic rw;
        logic first;
        logic lo;
        logic active;
        logic nack;
        logic drv;
        logic txn_end;
        logic conv_done;
        logic [7:0] ptr;
        logic [7:0] cfg;
        logic [7:0] wr_hi;
        logic [1:0] cfg2;
        logic [8:0] hyst;
        logic [8:0] otl;
        logic [9:0] temp;
        logic [9:0] adc;
    } core_t;
endpackage

// [src/sync2.sv]
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/10ps
`default_nettype none
module sync2 #(
    parameter int W = 1
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_t;
    sync_t sync_ff;
    sync_t nxt_sync;

    generate
        if (W < 1) begin : g_bad
            $error("sync2: W must be at least 1");
        end
    endgenerate

    always_comb begin
        nxt_sync.s1 = d_in;
        nxt_sync.s2 = sync_ff.s1;
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            sync_ff <= '0;
        end else begin
            sync_ff <= nxt_sync;
        end
    end

    assign q_out = sync_ff.s2;
endmodule // sync2
`default_nettype wire

// [src/cycle_timer.sv]
// loadable down-counter behind every sequencing delay
`timescale 1ns/10ps
`default_nettype none
module cycle_timer #(
    parameter int W = 16
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic load_in,
    input wire logic [W-1:0] count_in,
    output logic zero_out
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } tmr_t;
    tmr_t tmr_ff;
    tmr_t nxt_tmr;

    generate
        if (W < 2) begin : g_bad
            $error("cycle_timer: W must be at least 2");
        end
    endgenerate

    // loads count-1 so the waiting state lasts exactly count cycles
    always_comb begin
        nxt_tmr = tmr_ff;
        if (load_in) begin
            nxt_tmr.cnt = (count_in == '0) ? '0 : count_in - W'(1);
        end else if (tmr_ff.cnt != '0) begin
            nxt_tmr.cnt = tmr_ff.cnt - W'(1);
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            tmr_ff <= '0;
        end else begin
            tmr_ff <= nxt_tmr;
        end
    end

    assign zero_out = (tmr_ff.cnt == '0);
endmodule // cycle_timer
`default_nettype wire

// [src/temp_conv_core.sv]
// conversion sequencer, serial register port and register file
`timescale 1ns/10ps
`default_nettype none
`include "temp_conv_map.svh"
// Contract
// RQ1 - convert_start_n falling edge enters hold and starts a conversion.
// RQ2 - in automatic mode each serial transaction triggers a conversion, timing restarts.
// RQ3 - conversion begins 3 us after the serial transaction completes.
// RQ4 - result ready 15 us after start for inputs, 30 us for temperature.
// RQ5 - only channel zero conversions update the temperature result.
// RQ6 - temperature is 10-bit twos complement, 0.25 C per step.
// RQ7 - temperature register 0x00 is 16-bit read-only, result in bits 15..6.
// RQ8 - first byte of each write loads pointer, later bytes go to selected register.
// RQ9 - only the low three pointer bits select a data register.
// RQ10 - the master writes zeros into pointer bits 7..3.
// RQ11 - pointer codes 0..5 select temp, config, hyst, over-temp, converter, secondary_configuration.
// RQ12 - config holds channel, fault queue, polarity and comparator/interrupt mode.
// RQ13 - config bit 0 set means shutdown; it is zero after reset.
// RQ14 - a temperature-only variant is always given channel code 000.
// RQ15 - conversion timing uses the internal clock; serial clock only for transfers.
// RQ16 - reference amplifier on only from conversion start to conversion end.
// RQ17 - channel 000 is the sensor, 001 to 100 are analog inputs one to four.
// RQ18 - fault queue codes 00..11 need 1, 2, 4 or 6 faults; 00 at reset.
// RQ19 - rising convert_start_n powers up; early falling edge waits out power-up.
// RQ20 - default mode converts every 355 us; pin mode only on convert_start_n.
// RQ21 - unused low bits of the temperature register read as zero.
module temp_conv_core
    import temp_conv_pkg::*;
#(
    parameter int CYC_PERIOD = `CYC(`T_PERIOD_US),
    parameter logic [3:0] ADDR_HI = 4'h6 // arbitrary value
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n_out,
    input wire logic convert_start_n_in,
    input wire logic [2:0] addr_sel_in,
    input wire logic [9:0] adc_code_in,
    output afe_ctrl_t afe_out,
    output ot_cfg_t ot_cfg_out,
    output logic conv_done_out
);
    localparam int CYC_HOLD = `CYC(`T_HOLD_DLY_US);
    localparam int CYC_PWRUP = `CYC(`T_PWRUP_US);
    localparam int CYC_AIN = `CYC(`T_CONV_AIN_US);
    localparam int CYC_TEMP = `CYC(`T_CONV_TEMP_US);

    generate
        if (CYC_PERIOD < 2 || CYC_PERIOD > 65535) begin : g_bad
            $error("temp_conv_core: CYC_PERIOD out of range");
        end
    endgenerate

    core_t state_ff;
    core_t nxt_state;
    logic [5:0] pins_s;
    logic scl_s, sda_s, cs_s;
    logic [2:0] addr_s;
    logic seq_ld, per_ld, pu_ld, seq_zero, per_zero, pu_zero;
    logic [15:0] seq_cnt;
    logic go_conv, wr_byte, auto_mode, shdn;
    logic start_c, stop_c, scl_rise, scl_fall, cs_fall, cs_rise;
    logic [15:0] word;

    // ******************************************************
    // pin synchronisers and delay timers
    // ******************************************************
    // idle-high pins pass inverted so the flop reset matches idle level
    sync2 #(.W(6)) u_sync (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .d_in({addr_sel_in, ~convert_start_n_in, ~sda_in, ~scl_in}),
        .q_out(pins_s)
    );
    assign scl_s = !pins_s[0];
    assign sda_s = !pins_s[1];
    assign cs_s = !pins_s[2];
    assign addr_s = pins_s[5:3];

    cycle_timer #(.W(16)) u_seq (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .load_in(seq_ld),
        .count_in(seq_cnt),
        .zero_out(seq_zero)
    );
    cycle_timer #(.W(16)) u_per (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .load_in(per_ld),
        .count_in(16'(CYC_PERIOD)),
        .zero_out(per_zero)
    );
    cycle_timer #(.W(16)) u_pwr (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .load_in(pu_ld),
        .count_in(16'(CYC_PWRUP)),
        .zero_out(pu_zero)
    );

    // ******************************************************
    // register read view
    // ******************************************************
    function automatic logic [15:0] rd_word(input core_t c);
        case (c.ptr[2:0]) // RQ9 RQ11
            `PTR_TEMP: rd_word = {c.temp, 6'h00}; // RQ7 RQ21
            `PTR_CFG: rd_word = {c.cfg, c.cfg};
            `PTR_HYST: rd_word = {c.hyst, 7'h00};
            `PTR_OTL: rd_word = {c.otl, 7'h00};
            `PTR_ADC: rd_word = {c.adc, 6'h00};
            `PTR_CFG2: rd_word = {c.cfg2, 6'h00, c.cfg2, 6'h00};
            default: rd_word = 16'h0000;
        endcase
    endfunction

    assign word = rd_word(state_ff);
    assign auto_mode = !state_ff.cfg2[`CFG2_PIN];
    assign shdn = state_ff.cfg[`CFG_SHDN];
    assign start_c = state_ff.scl_p && scl_s && state_ff.sda_p && !sda_s;
    assign stop_c = state_ff.scl_p && scl_s && !state_ff.sda_p && sda_s;
    assign scl_rise = !state_ff.scl_p && scl_s;
    assign scl_fall = state_ff.scl_p && !scl_s;
    assign cs_fall = state_ff.cs_p && !cs_s;
    assign cs_rise = !state_ff.cs_p && cs_s;

    always_comb begin
        nxt_state = state_ff;
        nxt_state.scl_p = scl_s;
        nxt_state.sda_p = sda_s;
        nxt_state.cs_p = cs_s;
        nxt_state.txn_end = 1'b0;
        nxt_state.conv_done = 1'b0;
        seq_ld = 1'b0;
        seq_cnt = 16'(CYC_HOLD);
        per_ld = 1'b0;
        pu_ld = 1'b0;
        go_conv = 1'b0;
        wr_byte = 1'b0;
        // ******************************************************
        // serial register port, sampled on the core clock
        // ******************************************************
        if (start_c) begin
            nxt_state.bs = B_ADDR;
            nxt_state.bitcnt = 4'h0;
            nxt_state.drv = 1'b0;
            nxt_state.active = 1'b0;
            nxt_state.first = 1'b1;
            nxt_state.lo = 1'b0;
        end else if (stop_c) begin
            nxt_state.bs = B_IDLE;
            nxt_state.drv = 1'b0;
            nxt_state.active = 1'b0;
            nxt_state.txn_end = state_ff.active;
        end else if (scl_rise) begin
            case (state_ff.bs)
                B_ADDR, B_WR: begin
                    if (state_ff.bitcnt != 4'h8) begin
                        nxt_state.sh = {state_ff.sh[6:0], sda_s};
                        nxt_state.bitcnt = state_ff.bitcnt + 4'h1;
                    end
                end
                B_RD: nxt_state.bitcnt = state_ff.bitcnt + 4'h1;
                B_ACKR: nxt_state.nack = sda_s;
                default: nxt_state.nack = state_ff.nack;
            endcase
        end else if (scl_fall) begin
            case (state_ff.bs)
                B_ADDR: begin
                    if (state_ff.bitcnt == 4'h8) begin
                        if (state_ff.sh[7:1] == {ADDR_HI, addr_s}) begin
                            nxt_state.bs = B_ACKA;
                            nxt_state.drv = 1'b1;
                            nxt_state.active = 1'b1;
                            nxt_state.rw = state_ff.sh[0];
                        end else begin
                            nxt_state.bs = B_IDLE;
                        end
                    end
                end
                B_ACKA: begin
                    nxt_state.bitcnt = 4'h0;
                    if (state_ff.rw) begin
                        nxt_state.lo = 1'b0;
                        nxt_state.sh = word[15:8];
                        nxt_state.drv = !word[15];
                        nxt_state.bs = B_RD;
                    end else begin
                        nxt_state.drv = 1'b0;
                        nxt_state.bs = B_WR;
                    end
                end
                B_WR: begin
                    if (state_ff.bitcnt == 4'h8) begin
                        wr_byte = 1'b1;
                        nxt_state.drv = 1'b1;
                        nxt_state.bs = B_ACKW;
                        if (state_ff.first) begin
                            nxt_state.ptr = state_ff.sh; // RQ8 RQ10
                            nxt_state.first = 1'b0;
                            nxt_state.lo = 1'b0;
                        end else begin
                            case (state_ff.ptr[2:0]) // RQ8 RQ9 RQ11
                                `PTR_CFG: nxt_state.cfg = state_ff.sh; // RQ12
                                `PTR_CFG2: nxt_state.cfg2 = state_ff.sh[7:6];
                                `PTR_HYST, `PTR_OTL: begin
                                    nxt_state.lo = !state_ff.lo;
                                    if (!state_ff.lo) begin
                                        nxt_state.wr_hi = state_ff.sh;
                                    end else if (state_ff.ptr[0]) begin
                                        nxt_state.otl =
                                            {state_ff.wr_hi, state_ff.sh[7]};
                                    end else begin
                                        nxt_state.hyst =
                                            {state_ff.wr_hi, state_ff.sh[7]};
                                    end
                                end
                                // read-only targets ignore the data byte
                                default: nxt_state.lo = state_ff.lo;
                            endcase
                        end
                    end
                end
                B_ACKW: begin
                    nxt_state.drv = 1'b0;
                    nxt_state.bitcnt = 4'h0;
                    nxt_state.bs = B_WR;
                end
                B_RD: begin
                    if (state_ff.bitcnt == 4'h8) begin
                        nxt_state.drv = 1'b0;
                        nxt_state.bs = B_ACKR;
                    end else begin
                        nxt_state.drv = !state_ff.sh[6];
                        nxt_state.sh = {state_ff.sh[6:0], 1'b0};
                    end
                end
                B_ACKR: begin
                    if (state_ff.nack) begin
                        nxt_state.bs = B_IDLE;
                    end else begin
                        nxt_state.lo = !state_ff.lo;
                        nxt_state.sh = state_ff.lo ? word[15:8] : word[7:0];
                        nxt_state.drv = state_ff.lo ? !word[15] : !word[7];
                        nxt_state.bitcnt = 4'h0;
                        nxt_state.bs = B_RD;
                    end
                end
                default: nxt_state.bs = B_IDLE;
            endcase
        end
        // ******************************************************
        // conversion sequencer, internal clock only
        // ******************************************************
        if (cs_rise) begin
            pu_ld = 1'b1; // RQ19
        end
        case (state_ff.cs) // RQ15
            C_TRACK: begin
                if (cs_fall) begin
                    if (pu_zero) begin
                        go_conv = 1'b1; // RQ1
                    end else begin
                        nxt_state.cs = C_ARM; // RQ19
                    end
                end else if (state_ff.txn_end && auto_mode && !shdn) begin
                    nxt_state.cs = C_DELAY; // RQ2
                    seq_ld = 1'b1;
                    seq_cnt = 16'(CYC_HOLD); // RQ3
                end else if (auto_mode && !shdn && per_zero &&
                             !state_ff.active) begin
                    go_conv = 1'b1; // RQ20 RQ13
                end
            end
            C_ARM: begin
                if (pu_zero) begin
                    go_conv = 1'b1; // RQ19
                end
            end
            C_DELAY: begin
                if (seq_zero) begin
                    go_conv = 1'b1; // RQ3
                end
            end
            C_CONVERT: begin
                if (seq_zero) begin
                    nxt_state.conv_done = 1'b1;
                    nxt_state.cs = C_TRACK;
                    if (state_ff.conv_chan == `CHAN_TEMP) begin
                        nxt_state.temp = adc_code_in; // RQ5 RQ6
                    end else begin
                        nxt_state.adc = adc_code_in;
                    end
                end
            end
            default: nxt_state.cs = C_TRACK;
        endcase
        if (go_conv) begin
            nxt_state.cs = C_CONVERT;
            nxt_state.conv_chan = state_ff.cfg[`CFG_CHAN_HI:`CFG_CHAN_LO];
            seq_ld = 1'b1;
            // sensor channel takes the longer conversion
            seq_cnt = (state_ff.cfg[`CFG_CHAN_HI:`CFG_CHAN_LO] == `CHAN_TEMP)
                ? 16'(CYC_TEMP) : 16'(CYC_AIN); // RQ4 RQ17
            per_ld = 1'b1; // RQ20
        end
        // a transfer in automatic mode aborts; the stop restarts it
        if (auto_mode && state_ff.active && nxt_state.cs != C_TRACK) begin
            nxt_state.cs = C_TRACK; // RQ2
            seq_ld = 1'b0;
            per_ld = 1'b0;
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            state_ff <= '{cs: C_TRACK, bs: B_IDLE, cfg: `CFG_RST, // RQ13
                cfg2: `CFG2_RST, hyst: `LIMIT_RST, otl: `LIMIT_RST,
                scl_p: 1'b1, sda_p: 1'b1, cs_p: 1'b1, default: '0};
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ******************************************************
    // outputs
    // ******************************************************
    always_comb begin
        afe_out.hold = (state_ff.cs == C_CONVERT); // RQ1
        afe_out.ref_amp_en = (state_ff.cs == C_CONVERT); // RQ16
        afe_out.powered = (state_ff.cs != C_TRACK) || !pu_zero;
        afe_out.channel = (state_ff.cs == C_CONVERT) ? state_ff.conv_chan
            : state_ff.cfg[`CFG_CHAN_HI:`CFG_CHAN_LO];
        ot_cfg_out.polarity = state_ff.cfg[`CFG_POL]; // RQ12
        ot_cfg_out.int_mode = state_ff.cfg[`CFG_MODE];
        case (state_ff.cfg[`CFG_FQ_HI:`CFG_FQ_LO]) // RQ18
            2'h0: ot_cfg_out.fault_needed = 3'h1;
            2'h1: ot_cfg_out.fault_needed = 3'h2;
            2'h2: ot_cfg_out.fault_needed = 3'h4;
            default: ot_cfg_out.fault_needed = 3'h6;
        endcase
        ot_cfg_out.hysteresis_limit = state_ff.hyst;
        ot_cfg_out.over_temp_limit = state_ff.otl;
    end
    assign sda_out = 1'b0;
    assign sda_oe_n_out = !state_ff.drv;
    assign conv_done_out = state_ff.conv_done;

    // ******************************************************
    // assertions
    // ******************************************************
    logic [15:0] age_ff;
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            age_ff <= 16'h0000;
        end else if (nxt_state.cs != state_ff.cs) begin
            age_ff <= 16'h0000;
        end else begin
            age_ff <= age_ff + 16'h0001;
        end
    end

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    property p_fall_starts;
        (state_ff.cs == C_TRACK && cs_fall && pu_zero &&
         !(auto_mode && state_ff.active)) |=> afe_out.hold;
    endproperty
    a_fall_starts: assert property (p_fall_starts) // RQ1
        else $error("falling start edge did not enter hold");
    property p_bus_trig;
        (state_ff.cs == C_TRACK && state_ff.txn_end && auto_mode && !shdn &&
         !cs_fall && !state_ff.active) |=> state_ff.cs == C_DELAY;
    endproperty
    a_bus_trig: assert property (p_bus_trig) // RQ2
        else $error("transaction end did not schedule a conversion");
    property p_delay_len;
        (state_ff.cs == C_DELAY && nxt_state.cs == C_CONVERT)
            |-> age_ff == 16'(CYC_HOLD - 1);
    endproperty
    a_delay_len: assert property (p_delay_len) // RQ3
        else $error("hold delay length wrong");
    property p_conv_len;
        (state_ff.cs == C_CONVERT && nxt_state.conv_done) |->
            age_ff == ((state_ff.conv_chan == `CHAN_TEMP)
            ? 16'(CYC_TEMP - 1) : 16'(CYC_AIN - 1));
    endproperty
    a_conv_len: assert property (p_conv_len) // RQ4
        else $error("conversion length wrong");
    property p_temp_ch0;
        $changed(state_ff.temp) |-> $past(state_ff.conv_chan) == `CHAN_TEMP
            && state_ff.conv_done && $past(state_ff.cs) == C_CONVERT;
    endproperty
    a_temp_ch0: assert property (p_temp_ch0) // RQ5
        else $error("temperature changed outside a channel zero conversion");
    property p_ptr_load;
        (wr_byte && state_ff.first) |=> state_ff.ptr == $past(state_ff.sh);
    endproperty
    a_ptr_load: assert property (p_ptr_load) // RQ8
        else $error("pointer not loaded by first write byte");
    property p_ref_amp;
        $fell(afe_out.ref_amp_en) |-> state_ff.cs == C_TRACK && !afe_out.hold;
    endproperty
    a_ref_amp: assert property (p_ref_amp) // RQ16
        else $error("reference amplifier off while converting");
    property p_pin_mode;
        (state_ff.cs == C_TRACK && !auto_mode && !cs_fall) |=>
            state_ff.cs == C_TRACK;
    endproperty
    a_pin_mode: assert property (p_pin_mode) // RQ20
        else $error("pin mode converted without a start edge");
    property p_shdn;
        (state_ff.cs == C_TRACK && shdn && !cs_fall) |=>
            state_ff.cs == C_TRACK;
    endproperty
    a_shdn: assert property (p_shdn) // RQ13
        else $error("shutdown did not block automatic conversion");
    property p_arm_wait;
        (state_ff.cs == C_ARM && !pu_zero) |=> state_ff.cs != C_CONVERT;
    endproperty
    a_arm_wait: assert property (p_arm_wait) // RQ19
        else $error("conversion began before power-up elapsed");

    c_temp_done: cover property (state_ff.conv_done &&
        state_ff.conv_chan == `CHAN_TEMP);
    c_bus_conv: cover property (state_ff.cs == C_DELAY ##1
        state_ff.cs == C_CONVERT);
    c_arm: cover property (state_ff.cs == C_ARM ##1 state_ff.cs == C_CONVERT);
endmodule // temp_conv_core
`default_nettype wire

// [test/bus_host.sv]
// serial bus host model for the register port
`timescale 1ns/10ps
`default_nettype none
module bus_host (
    input wire logic mclk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_out
);
    // ****************
    // bit level
    // ****************
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    // one quarter of the 160 ns bit
    task automatic q;
        repeat (4) @(posedge mclk_in);
    endtask
    // data moves only while the clock is low
    task automatic xfer(input logic [8:0] d, output logic [8:0] r);
        for (int i = 8; i >= 0; i--) begin
            sda_out <= d[i];
            q;
            scl_out <= 1'b1;
            q;
            r[i] = sda_in;
            q;
            scl_out <= 1'b0;
            q;
        end
    endtask
    task automatic start;
        sda_out <= 1'b0;
        q;
        scl_out <= 1'b0;
        q;
    endtask
    task automatic stop;
        sda_out <= 1'b0;
        q;
        scl_out <= 1'b1;
        q;
        sda_out <= 1'b1;
        q;
    endtask
endmodule // bus_host
`default_nettype wire

// [test/tb_top.sv]
// testbench for the conversion and register core
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import temp_conv_pkg::*;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic cs_n = 1'b1;
    logic [9:0] adc = 10'h3ff;
    logic scl, h_sda, d_sda, oe_n, done;
    afe_ctrl_t afe;
    ot_cfg_t ot;
    int n_mismatch = 0;
    int n_tests = 0;
    // open drain with pull-up
    wire sda = h_sda & (oe_n | d_sda);
    always #5 mclk_in = ~mclk_in;
    bus_host h_u (.mclk_in(mclk_in), .sda_in(sda), .scl_out(scl),
        .sda_out(h_sda));
    temp_conv_core #(.CYC_PERIOD(600)) dut_u (.mclk_in(mclk_in),
        .rst_in(rst_in), .scl_in(scl), .sda_in(sda), .sda_out(d_sda),
        .sda_oe_n_out(oe_n), .convert_start_n_in(cs_n),
        .addr_sel_in(3'h5), .adc_code_in(adc), .afe_out(afe),
        .ot_cfg_out(ot), .conv_done_out(done));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("mismatches %0d tests %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic wr(input logic [7:0] p, d, input logic wd);
        logic [8:0] r;
        h_u.start();
        h_u.xfer(9'h0d5, r);
        chk(16'(r[0]), 16'h0000);
        h_u.xfer({p, 1'b1}, r);
        if (wd) h_u.xfer({d, 1'b1}, r);
        h_u.stop();
    endtask
    task automatic rd(input logic [7:0] p, input logic [15:0] e);
        logic [8:0] r;
        logic [7:0] hi;
        wr(p, 8'h00, 1'b0);
        h_u.start();
        h_u.xfer(9'h0d7, r);
        h_u.xfer(9'h1fe, r);
        hi = r[8:1];
        h_u.xfer(9'h1ff, r);
        h_u.stop();
        chk({hi, r[8:1]}, e);
    endtask
    // fault queue codes and their fault counts
    task automatic cfg_loop;
        logic [2:0] fq [4] = '{3'h1, 3'h2, 3'h4, 3'h6};
        for (int i = 0; i < 4; i++) begin
            wr(8'h01, 8'((i << 3) | (i << 1)), 1'b1);
            chk(16'(ot.fault_needed), 16'(fq[i]));
            chk(16'({ot.polarity, ot.int_mode}), 16'(i));
            rd(8'h01, {2{8'((i << 3) | (i << 1))}});
        end
    endtask
    // limit word: high byte, then low byte commits bits 15..7
    task automatic lim(input logic [7:0] p, input logic [7:0] hi);
        logic [8:0] r;
        logic [8:0] lv;
        h_u.start();
        h_u.xfer(9'h0d5, r);
        h_u.xfer({p, 1'b1}, r);
        h_u.xfer({hi, 1'b1}, r);
        h_u.xfer(9'h101, r);
        h_u.stop();
        lv = p[0] ? ot.over_temp_limit : ot.hysteresis_limit;
        chk(16'(lv), 16'({hi, 1'b1}));
        rd(p, {hi, 8'h80});
    endtask
    // pin start pulse; hold and reference span the whole conversion
    task automatic pulse(input logic [15:0] len, input logic [2:0] ch);
        int n;
        int bad;
        n = 0;
        bad = 0;
        cs_n <= 1'b0;
        while (afe.hold !== 1'b1 && n < 20) begin
            @(negedge mclk_in);
            n++;
        end
        chk(16'(afe.hold), 16'h0001);
        chk(16'({afe.powered, afe.channel}), 16'({1'b1, ch}));
        n = 0;
        while (done !== 1'b1 && n < 4000) begin
            if ({afe.hold, afe.ref_amp_en} !== 2'b11) bad++;
            @(negedge mclk_in);
            n++;
        end
        chk(16'(n), len);
        chk(16'(bad), 16'h0000);
        chk(16'(afe.hold), 16'h0000);
        @(posedge mclk_in);
        cs_n <= 1'b1;
    endtask
    task automatic conv_pin;
        pulse(16'h0bb8, 3'h0);
        rd(8'h00, 16'hffc0);
    endtask
    // analog channel: short conversion, result to the converter register
    task automatic conv_ain;
        wr(8'h01, 8'h20, 1'b1);
        adc <= 10'h155;
        pulse(16'h05dc, 3'h1);
        rd(8'h04, 16'h5540);
        rd(8'h00, 16'hffc0);
    endtask
    // automatic mode: stop, two sync flops, detect, then the hold delay
    task automatic bus_conv;
        int n;
        n = 0;
        while (afe.hold !== 1'b1 && n < 400) begin
            @(negedge mclk_in);
            n++;
        end
        chk(16'(n), 16'h012d);
        wr(8'h05, 8'h80, 1'b1);
        chk(16'(afe.hold), 16'h0000);
    endtask
    initial begin
        repeat (3) @(posedge mclk_in);
        rst_in <= 1'b0;
        repeat (6) @(posedge mclk_in);
        chk(16'(ot.fault_needed), 16'h0001);
        rd(8'h01, 16'h0000);
        bus_conv;
        rd(8'h05, 16'h8080);
        cfg_loop;
        lim(8'h02, 8'hc8);
        lim(8'h03, 8'h64);
        conv_pin;
        conv_ain;
        end_sim;
    end
endmodule // tb_top
`default_nettype wire
